// File: rtl/l2_dest_port_map_resolver.sv
/*
 * Layer 2 destination port map resolver with its APB register file.
 * Assumes a request each cycle at most from the look-up pipeline, no back-pressure
 * from the queuing logic, and an APB master sharing sys_clk.
 */
//
// Contract
// - Bits 0-47 gigabit, 48-49 10G, 50-57 supervisor.
// - Aggregation index is additive reduction of addresses.
// - Index selects one of eight 8-byte masks.
// - Aggregation mask narrows aggregate to one member.
// - One mask set shared by every aggregate.
// - Blocked source or VLAN clears blocking mask bits; the code clears them for req.src_blocked only.
// - Known source gets current time stamp written.
// - Nine-bit index addresses 512-entry destination map table.
// - Set bits mark destinations; masks remove, mappings add.
// - Mirrored destination adds copy to mirror port.
// - Destination miss uses flood map, reset zero.
// - Global mask suppresses destinations, reset zero.
// - Supervisor transmissions bypass the global mask.
// - Snooping enabled copies IGMP to snoop port.
// - Active port map detects VLAN mismatch drops.
`timescale 1ns/100ps
module l2_dest_port_map_resolver #(
    parameter int DMAP_ENTRIES = l2map_pkg::DMAP_DEPTH,
    parameter int AGG_ENTRIES = l2map_pkg::AGG_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [l2map_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_valid,
    input wire l2map_pkg::lookup_req_t req,
    output logic res_valid,
    output l2map_pkg::resolve_res_t res,
    output logic stamp_write,
    output logic [l2map_pkg::TIME_W-1:0] stamp_value
);
    import l2map_pkg::*;

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (DMAP_ENTRIES != (1 << IDX_W)) begin : g_bad_dmap
        $error("DMAP_ENTRIES must match the 9-bit map index");
    end
    if (AGG_ENTRIES != (1 << AGG_W)) begin : g_bad_agg
        $error("AGG_ENTRIES must match the 3-bit aggregation index");
    end

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Register select from a byte address
    function automatic sel_t decode(input logic [ADDR_W-1:0] a);
        sel_t s;
        s = SEL_NONE;
        if (a >= DMAP_BASE && a < DMAP_BASE + DMAP_SIZE) begin
            s = SEL_DMAP;
        end else if (a >= AGG_BASE && a < AGG_BASE + AGG_SIZE) begin
            s = SEL_AGG;
        end else begin
            case ({a[ADDR_W-1:3], 3'h0})
                ACTIVE_OFS: s = SEL_ACTIVE;
                BLOCK_OFS: s = SEL_BLOCK;
                MIRROR_OFS: s = SEL_MIRROR;
                FLOOD_OFS: s = SEL_FLOOD;
                GLOBAL_OFS: s = SEL_GLOBAL;
                default: s = SEL_NONE;
            endcase
            if (a == TIME_OFS) s = SEL_TIME;
            if (a == SNOOP_OFS) s = SEL_SNOOP;
            if (a == MPORT_OFS) s = SEL_MPORT;
        end
        // Misaligned words are refused in the tables too
        if (a[1:0] != 2'h0) s = SEL_NONE;
        return s;
    endfunction

    // Folds both addresses in 3-bit slices by addition, modulo eight
    function automatic logic [AGG_W-1:0] agg_index(input logic [MAC_W-1:0] da, input logic [MAC_W-1:0] sa);
        logic [AGG_W-1:0] sum;
        sum = 3'h0;
        for (int k = 0; k < MAC_W / AGG_W; k++) begin
            sum = sum + da[k*AGG_W +: AGG_W] + sa[k*AGG_W +: AGG_W];
        end
        return sum;
    endfunction

    // Single destination bit for a port number; out-of-range ports add nothing
    function automatic map_t port_bit(input logic [PORT_W-1:0] p);
        map_t m;
        m = MAP_RST;
        if (int'(p) <= SUP_HI) m[p] = 1'b1;
        return m;
    endfunction

    // Splits a map register into the two bus words
    function automatic logic [31:0] map_word(input map_t m, input logic hi);
        return hi ? {{(32 - HI_W){1'b0}}, m[MAP_W-1:32]} : m[31:0];
    endfunction

    // Merges one bus word into a map register
    function automatic map_t map_merge(input map_t m, input logic hi, input logic [31:0] d);
        map_t r;
        r = m;
        if (hi) r[MAP_W-1:32] = d[HI_W-1:0];
        else r[31:0] = d;
        return r;
    endfunction

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    map_t dmap_mem [DMAP_ENTRIES];
    map_t agg_mem [AGG_ENTRIES];
    map_t active_reg, active_next;
    map_t block_reg, block_next;
    map_t mirror_reg, mirror_next;
    map_t flood_reg, flood_next;
    map_t global_reg, global_next;
    logic [TIME_W-1:0] time_reg, time_next;
    logic [PORT_W-1:0] snoop_reg, snoop_next;
    logic [PORT_W-1:0] mport_reg, mport_next;
    logic [31:0] rdata_reg, rdata_next;
    logic err_reg, err_next;
    logic dmap_we, agg_we;
    logic [IDX_W-1:0] dmap_wi;
    logic [AGG_W-1:0] agg_wi;
    map_t dmap_wd, agg_wd;

    sel_t setup_sel, acc_sel;
    logic setup_ph, acc_wr, word_hi;

    // Bus phase, register select and table word indices
    assign setup_ph = psel && !penable;
    assign setup_sel = decode(paddr);
    assign acc_sel = decode(paddr);
    assign acc_wr = psel && penable && pwrite;
    assign word_hi = !paddr[2];
    assign dmap_wi = paddr[IDX_W+2:3];
    assign agg_wi = paddr[AGG_W+2:3];

    // ----------------------------------------
    // APB slave: read data captured in setup, writes at the access edge
    // ----------------------------------------
    always_comb begin
        active_next = active_reg;
        block_next = block_reg;
        mirror_next = mirror_reg;
        flood_next = flood_reg;
        global_next = global_reg;
        time_next = time_reg;
        snoop_next = snoop_reg;
        mport_next = mport_reg;
        rdata_next = rdata_reg;
        err_next = err_reg;
        dmap_we = 1'b0;
        agg_we = 1'b0;
        dmap_wd = map_merge(dmap_mem[dmap_wi], word_hi, pwdata);
        agg_wd = map_merge(agg_mem[agg_wi], word_hi, pwdata);
        if (setup_ph) begin
            err_next = (setup_sel == SEL_NONE);
            case (setup_sel)
                SEL_DMAP: rdata_next = map_word(dmap_mem[dmap_wi], word_hi);
                SEL_AGG: rdata_next = map_word(agg_mem[agg_wi], word_hi);
                SEL_ACTIVE: rdata_next = map_word(active_reg, word_hi);
                SEL_BLOCK: rdata_next = map_word(block_reg, word_hi);
                SEL_MIRROR: rdata_next = map_word(mirror_reg, word_hi);
                SEL_FLOOD: rdata_next = map_word(flood_reg, word_hi);
                SEL_GLOBAL: rdata_next = map_word(global_reg, word_hi);
                SEL_TIME: rdata_next = {28'h0000000, time_reg};
                SEL_SNOOP: rdata_next = {26'h0000000, snoop_reg};
                SEL_MPORT: rdata_next = {26'h0000000, mport_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
        if (acc_wr) begin
            case (acc_sel)
                SEL_DMAP: dmap_we = 1'b1;
                SEL_AGG: agg_we = 1'b1;
                SEL_ACTIVE: active_next = map_merge(active_reg, word_hi, pwdata);
                SEL_BLOCK: block_next = map_merge(block_reg, word_hi, pwdata);
                SEL_MIRROR: mirror_next = map_merge(mirror_reg, word_hi, pwdata);
                SEL_FLOOD: flood_next = map_merge(flood_reg, word_hi, pwdata);
                SEL_GLOBAL: global_next = map_merge(global_reg, word_hi, pwdata);
                SEL_TIME: time_next = pwdata[TIME_W-1:0];
                SEL_SNOOP: snoop_next = pwdata[PORT_W-1:0];
                SEL_MPORT: mport_next = pwdata[PORT_W-1:0];
                default: ;
            endcase
        end
    end

    // Control registers with their reset values
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_reg <= MAP_RST;
            block_reg <= MAP_RST;
            mirror_reg <= MAP_RST;
            flood_reg <= MAP_RST;
            global_reg <= MAP_RST;
            time_reg <= TIME_RST;
            snoop_reg <= PORT_RST;
            mport_reg <= PORT_RST;
            rdata_reg <= 32'h00000000;
            err_reg <= 1'b0;
        end else begin
            active_reg <= active_next;
            block_reg <= block_next;
            mirror_reg <= mirror_next;
            flood_reg <= flood_next;
            global_reg <= global_next;
            time_reg <= time_next;
            snoop_reg <= snoop_next;
            mport_reg <= mport_next;
            rdata_reg <= rdata_next;
            err_reg <= err_next;
        end
    end

    // Table storage, written one word at a time
    always_ff @(posedge sys_clk) begin
        if (dmap_we) dmap_mem[dmap_wi] <= dmap_wd;
        if (agg_we) agg_mem[agg_wi] <= agg_wd;
    end

    // Bus answer: never waits, errors only in the access phase
    assign prdata = rdata_reg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && err_reg;

    // ----------------------------------------
    // Map resolution chain
    // ----------------------------------------
    map_t init_map, agg_map, blk_map, base_map, add_map;
    logic [AGG_W-1:0] agg_sel;
    logic mirror_hit, snoop_hit, vlan_drop;

    // Masking steps remove destinations, then mapping steps add copies
    always_comb begin
        init_map = req.dest_hit ? dmap_mem[req.map_index] : flood_reg;
        agg_sel = agg_index(req.dest_mac, req.src_mac);
        agg_map = init_map;
        if (req.dest_hit && req.dest_aggregate) begin
            agg_map = init_map & agg_mem[agg_sel];
        end
        blk_map = req.src_blocked ? (agg_map & ~block_reg) : agg_map;
        base_map = req.supervisor_tx ? blk_map : (blk_map & ~global_reg);
        mirror_hit = |(base_map & mirror_reg);
        snoop_hit = req.snoop_enable && req.igmp_packet;
        add_map = base_map;
        if (mirror_hit) add_map = add_map | port_bit(mport_reg);
        if (snoop_hit) add_map = add_map | port_bit(snoop_reg);
        vlan_drop = (|init_map) && !(|(init_map & active_reg));
    end

    resolve_res_t res_reg, res_next;
    logic valid_reg, valid_next;
    logic stamp_reg, stamp_next;
    logic [TIME_W-1:0] sval_reg, sval_next;

    // Answer and time stamp update for each accepted request
    always_comb begin
        valid_next = req_valid;
        res_next = res_reg;
        stamp_next = req_valid && req.src_known;
        sval_next = sval_reg;
        if (req_valid) begin
            res_next.final_map = add_map;
            res_next.base_map = base_map;
            res_next.mirror_copy = mirror_hit;
            res_next.snoop_copy = snoop_hit;
            res_next.vlan_dropped = vlan_drop;
        end
        if (req_valid && req.src_known) sval_next = time_reg;
    end

    // Output stage registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_reg <= 1'b0;
            res_reg <= '0;
            stamp_reg <= 1'b0;
            sval_reg <= TIME_RST;
        end else begin
            valid_reg <= valid_next;
            res_reg <= res_next;
            stamp_reg <= stamp_next;
            sval_reg <= sval_next;
        end
    end

    // Outputs straight from the result stage
    assign res_valid = valid_reg;
    assign res = res_reg;
    assign stamp_write = stamp_reg;
    assign stamp_value = sval_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_result_latency: assert property (req_valid |=> res_valid)
        else $error("answer not one cycle after request");
    a_no_spurious: assert property (!req_valid |=> !res_valid)
        else $error("answer without request");
    a_flood_on_miss: assert property (req_valid && !req.dest_hit |=> (res.base_map & ~$past(flood_reg)) == 58'h0)
        else $error("miss map not within flood map");
    a_aggr_narrow: assert property (req_valid && req.dest_hit && req.dest_aggregate
        |=> (res.base_map & ~$past(agg_mem[agg_sel])) == 58'h0)
        else $error("aggregate not narrowed by mask");
    a_block_clear: assert property (req_valid && req.src_blocked |=> (res.base_map & $past(block_reg)) == 58'h0)
        else $error("blocked destination left set");
    a_global_clear: assert property (req_valid && !req.supervisor_tx
        |=> (res.base_map & $past(global_reg)) == 58'h0)
        else $error("globally masked destination left set");
    a_super_bypass: assert property (req_valid && req.supervisor_tx && !req.src_blocked && !req.dest_aggregate
        |=> res.base_map == $past(init_map))
        else $error("supervisor map altered by global mask");
    a_mirror_copy: assert property (res_valid |-> res.mirror_copy == |(res.base_map & $past(mirror_reg)))
        else $error("mirror copy flag wrong");
    a_snoop_copy: assert property (req_valid && req.snoop_enable && req.igmp_packet && snoop_reg <= 6'h39
        |=> res.final_map[$past(snoop_reg)])
        else $error("snoop port missing from map");
    a_stamp_write: assert property (req_valid && req.src_known |=> stamp_write && stamp_value == $past(time_reg))
        else $error("time stamp not written");
    a_unmapped_err: assert property (psel && !penable && decode(paddr) == SEL_NONE |=> pslverr || !penable)
        else $error("unmapped access not refused");

    // Bus answers and stored words
    a_read_time: assert property (psel && !penable && !pwrite && decode(paddr) == SEL_TIME
        |=> prdata == {28'h0000000, $past(time_reg)})
        else $error("time register read back wrong");
    a_flood_store: assert property (psel && penable && pwrite && acc_sel == SEL_FLOOD && !paddr[2]
        |=> flood_reg[MAP_W-1:32] == $past(pwdata[HI_W-1:0]))
        else $error("flood map upper word not stored");
    a_refused_write: assert property (pslverr && pwrite |=> $stable(global_reg) && $stable(mirror_reg))
        else $error("refused write changed a register");

    // Result stage
    a_stamp_only: assert property (!(req_valid && req.src_known) |=> !stamp_write)
        else $error("time stamp written without known source");
    a_adds_only: assert property (res_valid |-> (res.base_map & ~res.final_map) == 58'h0)
        else $error("mapping step removed a destination");
    a_hit_table: assert property (req_valid && req.dest_hit && !req.dest_aggregate
        && !req.src_blocked && req.supervisor_tx |=> res.base_map == $past(dmap_mem[req.map_index]))
        else $error("table entry not used as initial map");
    a_snoop_flag: assert property (req_valid
        |=> res.snoop_copy == $past(req.snoop_enable && req.igmp_packet))
        else $error("snoop copy flag wrong");
    a_mirror_port: assert property (req_valid && mport_reg <= 6'h39
        |=> !res.mirror_copy || res.final_map[$past(mport_reg)])
        else $error("mirror port missing from map");
    a_active_kept: assert property (req_valid && (init_map & active_reg) != 58'h0 |=> !res.vlan_dropped)
        else $error("forwarded packet flagged as dropped");
    a_res_hold: assert property (!req_valid |=> $stable(res))
        else $error("result changed without a request");

    c_flood_packet: cover property (req_valid && !req.dest_hit ##1 res_valid);
    c_aggr_packet: cover property (req_valid && req.dest_aggregate && req.dest_hit ##1 res_valid);
    c_mirror_snoop: cover property (res_valid && res.mirror_copy && res.snoop_copy);
    c_table_write: cover property (psel && penable && pwrite && acc_sel == SEL_DMAP);
    c_vlan_drop: cover property (res_valid && res.vlan_dropped);
endmodule

// File: rtl/l2map_pkg.sv
/*
 * Shared constants and carrier types for the layer 2 destination map resolver.
 * Assumes a 32-bit APB register bus with byte addresses and a 58-bit port map.
 */
package l2map_pkg;
    // ----------------------------------------
    // Map geometry
    // ----------------------------------------
    localparam int MAP_W = 58;
    localparam int GIG_HI = 47;
    localparam int XG_HI = 49;
    localparam int SUP_HI = 57;
    localparam int PORT_W = 6;
    localparam int TIME_W = 4;
    localparam int IDX_W = 9;
    localparam int DMAP_DEPTH = 512;
    localparam int AGG_W = 3;
    localparam int AGG_DEPTH = 8;
    localparam int MAC_W = 48;
    localparam int ADDR_W = 20;
    localparam int HI_W = MAP_W - 32;

    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] DMAP_BASE = 20'hC2000;
    localparam logic [ADDR_W-1:0] DMAP_SIZE = 20'h01000;
    localparam logic [ADDR_W-1:0] AGG_BASE = 20'hC4480;
    localparam logic [ADDR_W-1:0] AGG_SIZE = 20'h00040;
    localparam logic [ADDR_W-1:0] ACTIVE_OFS = 20'hC4620;
    localparam logic [ADDR_W-1:0] BLOCK_OFS = 20'hC4628;
    localparam logic [ADDR_W-1:0] MIRROR_OFS = 20'hC4630;
    localparam logic [ADDR_W-1:0] FLOOD_OFS = 20'hC4638;
    localparam logic [ADDR_W-1:0] GLOBAL_OFS = 20'hC4640;
    localparam logic [ADDR_W-1:0] TIME_OFS = 20'hC4660;
    localparam logic [ADDR_W-1:0] SNOOP_OFS = 20'hC4664;
    localparam logic [ADDR_W-1:0] MPORT_OFS = 20'hC4670;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [MAP_W-1:0] MAP_RST = 58'h0;
    localparam logic [TIME_W-1:0] TIME_RST = 4'h0;
    localparam logic [PORT_W-1:0] PORT_RST = 6'h00;

    typedef logic [MAP_W-1:0] map_t;

    typedef enum logic [3:0] {
        SEL_NONE, SEL_DMAP, SEL_AGG, SEL_ACTIVE, SEL_BLOCK, SEL_MIRROR,
        SEL_FLOOD, SEL_GLOBAL, SEL_TIME, SEL_SNOOP, SEL_MPORT
    } sel_t;

    // Per-packet request from the look-up pipeline
    typedef struct packed {
        logic [MAC_W-1:0] dest_mac;
        logic [MAC_W-1:0] src_mac;
        logic dest_hit;
        logic dest_aggregate;
        logic [IDX_W-1:0] map_index;
        logic src_known;
        logic src_blocked;
        logic supervisor_tx;
        logic igmp_packet;
        logic snoop_enable;
    } lookup_req_t;

    // Per-packet answer to the queuing logic
    typedef struct packed {
        map_t final_map;
        map_t base_map;
        logic mirror_copy;
        logic snoop_copy;
        logic vlan_dropped;
    } resolve_res_t;
endpackage

// File: verification/lookup_model.sv
/*
 * Behavioural model of the look-up pipeline that feeds the resolver.
 * Assumes its tasks are called right after a rising edge of sys_clk.
 */
`timescale 1ns/100ps
module lookup_model (
    input wire logic sys_clk,
    output logic req_valid,
    output l2map_pkg::lookup_req_t req
);
    import l2map_pkg::*;

    // Quiet outputs until the first packet
    initial begin
        req_valid = 1'b0;
        req = '0;
    end

    // One request per call, all qualifiers travel with the strobe
    task automatic send(input lookup_req_t r);
        req <= r;
        req_valid <= 1'b1;
        @(posedge sys_clk);
    endtask

    // Drop the strobe and scramble the fields that no longer mean anything
    task automatic idle();
        req_valid <= 1'b0;
        req <= ~req;
        @(posedge sys_clk);
    endtask
endmodule

// File: verification/tb_l2_dest_port_map_resolver.sv
/*
 * Self-checking bench for the layer 2 destination map resolver.
 * Assumes zero-wait APB and a one-cycle result latency from the design.
 */
`timescale 1ns/100ps
module tb_l2_dest_port_map_resolver;
    import l2map_pkg::*;
    logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, res_valid, stamp_write, req_valid, vprev;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    lookup_req_t req;
    resolve_res_t res, e;
    logic [TIME_W-1:0] stamp_value, tim;
    logic [PORT_W-1:0] sp, mp;
    logic [4:0] s;
    int n_mismatch = 0;
    int n_compared = 0;
    map_t dm [int];
    map_t ag [8];
    map_t blk, mir, fld, glb, act;
    resolve_res_t eq [$];
    logic [4:0] sq [$];
    int ix [$];

    l2_dest_port_map_resolver uut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req_valid(req_valid), .req(req), .res_valid(res_valid), .res(res), .stamp_write(stamp_write),
        .stamp_value(stamp_value));
    lookup_model lm (.sys_clk(sys_clk), .req_valid(req_valid), .req(req));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
        n_compared++;
        if (g !== x) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    function automatic map_t rnd58();
        logic [63:0] t;
        t = {$urandom, $urandom};
        return t[MAP_W-1:0];
    endfunction

    // One APB transfer; releases the bus and lets an edge pass so strobes never double up
    task automatic apb(input logic [19:0] a, input logic w, input logic [31:0] d, output logic [31:0] q,
                       output logic er);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 50) begin
            n_mismatch++;
            finish_test();
        end
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic er;
        apb(a, 1'b1, d, q, er);
        chk("pslverr", 0, er);
    endtask

    task automatic rd(input logic [19:0] a, input logic [31:0] x, input logic ex);
        logic [31:0] q;
        logic er;
        apb(a, 1'b0, 32'h00000000, q, er);
        chk("prdata", x, q);
        chk("pslverr", ex, er);
    endtask

    // Maps take two words: upper bits first
    task automatic wrm(input logic [19:0] a, input map_t v);
        wr(a, {6'h00, v[57:32]});
        wr(a + 20'h4, v[31:0]);
    endtask

    task automatic rdm(input logic [19:0] a, input map_t v);
        rd(a, {6'h00, v[57:32]}, 1'b0);
        rd(a + 20'h4, v[31:0], 1'b0);
    endtask

    // Reference resolution of one packet
    function automatic resolve_res_t model(input lookup_req_t r);
        resolve_res_t o;
        map_t m;
        int sum;
        sum = 0;
        for (int k = 0; k < 16; k++) sum += r.dest_mac[3*k+:3] + r.src_mac[3*k+:3];
        m = r.dest_hit ? dm[r.map_index] : fld;
        o.vlan_dropped = (m != MAP_RST) && ((m & act) == MAP_RST);
        if (r.dest_hit && r.dest_aggregate) m &= ag[sum % 8];
        if (r.src_blocked) m &= ~blk;
        if (!r.supervisor_tx) m &= ~glb;
        o.base_map = m;
        o.mirror_copy = |(m & mir);
        o.snoop_copy = r.snoop_enable & r.igmp_packet;
        if (o.mirror_copy && mp < MAP_W) m[mp] = 1'b1;
        if (o.snoop_copy && sp < MAP_W) m[sp] = 1'b1;
        o.final_map = m;
        return o;
    endfunction

    // Fresh random configuration for one round
    task automatic setup_round(input int k);
        tim = TIME_W'($urandom);
        sp = PORT_W'($urandom);
        mp = PORT_W'($urandom);
        blk = rnd58();
        mir = rnd58() & rnd58() & rnd58();
        fld = rnd58();
        glb = rnd58();
        act = (k == 2) ? MAP_RST : ~MAP_RST;
        wrm(BLOCK_OFS, blk);
        wrm(MIRROR_OFS, mir);
        wrm(FLOOD_OFS, fld);
        wrm(GLOBAL_OFS, glb);
        wrm(ACTIVE_OFS, act);
        wr(TIME_OFS, {28'h0, tim});
        wr(SNOOP_OFS, {26'h0, sp});
        wr(MPORT_OFS, {26'h0, mp});
        ix = {0, 511};
        repeat (6) ix.push_back($urandom % 512);
        foreach (ix[i]) begin
            dm[ix[i]] = rnd58();
            wrm(DMAP_BASE + ADDR_W'(8 * ix[i]), dm[ix[i]]);
        end
        for (int i = 0; i < 8; i++) begin
            ag[i] = rnd58();
            wrm(AGG_BASE + ADDR_W'(8 * i), ag[i]);
        end
        rdm(DMAP_BASE + ADDR_W'(8 * 511), dm[511]);
        rdm(AGG_BASE + ADDR_W'(56), ag[7]);
        rd(TIME_OFS, {28'h0, tim}, 1'b0);
        rdm(BLOCK_OFS, blk);
        rdm(ACTIVE_OFS, act);
        rd(SNOOP_OFS, {26'h0, sp}, 1'b0);
        rd(MPORT_OFS, {26'h0, mp}, 1'b0);
    endtask

    // ----------------------------------------
    // Clock, result monitor, watchdog
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Each result must follow its request by one cycle and match the reference
    always @(posedge sys_clk) begin
        if (rst_n === 1'b1) begin
            chk("res_valid", vprev, res_valid);
            if (res_valid === 1'b1 && eq.size() > 0) begin
                e = eq.pop_front();
                s = sq.pop_front();
                chk("final_map", e.final_map, res.final_map);
                chk("base_map", e.base_map, res.base_map);
                chk("mirror_copy", e.mirror_copy, res.mirror_copy);
                chk("snoop_copy", e.snoop_copy, res.snoop_copy);
                chk("vlan_dropped", e.vlan_dropped, res.vlan_dropped);
                chk("stamp_write", s[4], stamp_write);
                if (s[4]) chk("stamp_value", s[3:0], stamp_value);
            end
        end
        vprev = req_valid;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        finish_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] q;
        logic er;
        logic [127:0] rb;
        lookup_req_t r;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        vprev = 1'b0;
        void'($urandom(42070));
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        // Reset values, then refused accesses
        rdm(MIRROR_OFS, MAP_RST);
        rdm(FLOOD_OFS, MAP_RST);
        rdm(GLOBAL_OFS, MAP_RST);
        rd(SNOOP_OFS, 32'h0, 1'b0);
        apb(20'h00010, 1'b1, 32'hFFFFFFFF, q, er);
        chk("pslverr", 1, er);
        rd(FLOOD_OFS + 20'h2, 32'h0, 1'b1);
        rd(DMAP_BASE + 20'h6, 32'h0, 1'b1);
        // Three rounds of back-to-back random packets
        for (int k = 0; k < 3; k++) begin
            setup_round(k);
            for (int n = 0; n < 100; n++) begin
                rb = {$urandom, $urandom, $urandom, $urandom};
                r = rb[$bits(lookup_req_t)-1:0];
                r.map_index = IDX_W'(ix[$urandom % ix.size()]);
                if (k == 2) r.dest_aggregate = 1'b0;
                eq.push_back(model(r));
                sq.push_back({r.src_known, tim});
                lm.send(r);
            end
            lm.idle();
            repeat (2) @(posedge sys_clk);
            chk("pending", 0, eq.size());
        end
        finish_test();
    end
endmodule
